// >>> hw/tmoc_map.vh
`ifndef TMOC_MAP_VH
`define TMOC_MAP_VH

// Register byte offsets.
`define TMOC_CTRL_OFF 8'h00
`define TMOC_FORCE_OFF 8'h04
`define TMOC_COUNT_OFF 8'h08
`define TMOC_CMPA_OFF 8'h0C
`define TMOC_CMPB_OFF 8'h10
`define TMOC_FLAGS_OFF 8'h14
`define TMOC_IEN_OFF 8'h18
`define TMOC_STAT_OFF 8'h1C

// Control register fields.
`define TMOC_ACT_A_LSB 0
`define TMOC_ACT_B_LSB 2
`define TMOC_MODE_LSB 4

// Flag and enable bit positions.
`define TMOC_OVF_BIT 0
`define TMOC_FLA_BIT 1
`define TMOC_FLB_BIT 2

// Waveform mode encodings.
`define TMOC_MODE_NORMAL 3'h0
`define TMOC_MODE_PHASE_FF 3'h1
`define TMOC_MODE_CTC 3'h2
`define TMOC_MODE_FAST_FF 3'h3
`define TMOC_MODE_PHASE_A 3'h5
`define TMOC_MODE_FAST_A 3'h7

// Counter extremes and reset values.
`define TMOC_MAX 8'hFF
`define TMOC_BOTTOM 8'h00
`define TMOC_CMP_RST 8'h00
`define TMOC_CTRL_RST 7'h00

`endif

// >>> hw/tmoc_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_map.vh"

module tmoc_counter (
    input wire pclk,
    input wire presetn,
    input wire tick,
    input wire [2:0] mode,
    input wire [7:0] top,
    input wire cnt_wr,
    input wire [7:0] cnt_wdata,
    output reg [7:0] cnt_q,
    output reg up_q,
    output wire ovf_ev,
    output wire wrap_ev
);
    wire fast;
    wire phase;
    wire at_top;
    reg [7:0] cnt_d;
    reg up_d;

    assign fast = mode[0] & mode[1];
    assign phase = mode[0] & ~mode[1];
    assign at_top = (cnt_q == top);
    assign wrap_ev = tick & fast & at_top;

    // Next count and direction; only the mode steers the sequence. [RL17]
    always @* begin
        cnt_d = cnt_q + 8'h01; // [RL19]
        up_d = 1'b1;
        if (phase) begin // [RL26]
            up_d = at_top ? 1'b0 : (cnt_q == `TMOC_BOTTOM) ? 1'b1 : up_q;
            cnt_d = up_d ? cnt_q + 8'h01 : cnt_q - 8'h01;
        end else if (fast || mode == `TMOC_MODE_CTC) begin // [RL24] [RL25]
            if (at_top) begin
                cnt_d = `TMOC_BOTTOM;
            end
        end
    end

    // Overflow event: wrap from MAX, top in fast mode, bottom in phase mode. [RL20]
    assign ovf_ev = tick & (phase ? (cnt_d == `TMOC_BOTTOM && cnt_q != `TMOC_BOTTOM) :
                            fast ? at_top : (cnt_q == `TMOC_MAX));

    // A processor write wins over counting at any time. [RL27] [RL22]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            up_q <= 1'b1;
        end else if (cnt_wr) begin
            cnt_q <= cnt_wdata;
        end else if (tick) begin
            cnt_q <= cnt_d;
            up_q <= up_d;
        end
    end
endmodule

`default_nettype wire

// >>> hw/tmoc_wave.v
`timescale 1ns/1ps
`default_nettype none

module tmoc_wave (
    input wire pclk,
    input wire presetn,
    input wire match_ev,
    input wire force_ev,
    input wire [1:0] action,
    input wire fast,
    input wire phase,
    input wire rising,
    input wire wrap_ev,
    input wire toggle_ok,
    output reg state_q
);
    reg state_d;

    // Output state update per mode and action; action zero leaves it alone. [RL16] [RL18]
    always @* begin
        state_d = state_q;
        if (fast) begin
            if (wrap_ev && action[1]) begin
                state_d = ~action[0]; // Bottom wins so a MAX compare holds steady. [RL23]
            end else if (match_ev) begin
                if (action[1]) begin
                    state_d = action[0];
                end else if (action[0] && toggle_ok) begin
                    state_d = ~state_q;
                end
            end
        end else if (phase) begin
            if (match_ev) begin
                if (action[1]) begin
                    state_d = rising ? action[0] : ~action[0]; // [RL23]
                end else if (action[0] && toggle_ok) begin
                    state_d = ~state_q;
                end
            end
        end else if (match_ev || force_ev) begin // [RL7]
            case (action)
                2'h1: state_d = ~state_q;
                2'h2: state_d = 1'b0;
                2'h3: state_d = 1'b1;
                default: state_d = state_q;
            endcase
        end
    end

    // State resets low and is not touched on a mode change. [RL13] [RL11]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= 1'b0;
        end else begin
            state_q <= state_d; // [RL12]
        end
    end
endmodule

`default_nettype wire

// >>> hw/tmoc_top.v
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_map.vh"

// Operation
// (RL1) Count is compared with both compare values all the time.
// (RL2) A match sets the channel flag on the following timer tick.
// (RL3) Enabled flag requests interrupt; flag clears when interrupt is taken.
// (RL4) Writing one to a flag bit clears that flag.
// (RL5) Compare registers double buffered only in PWM modes.
// (RL6) Buffered: software sees buffer; otherwise the active compare register.
// (RL7) Force strobe acts as match on output only, non-PWM modes.
// (RL8) Count write blocks compare matches in the next timer tick.
// (RL9) Software avoids writing count equal to compare or bottom downcounting.
// (RL10) Software sets output state before making the pin an output.
// (RL11) Output state keeps its value across mode changes.
// (RL12) Action bits act at once, from the next match.
// (RL13) Reset clears each output state bit.
// (RL14) Nonzero action overrides port value; direction stays with port.
// (RL15) Port override does not depend on waveform mode.
// (RL16) Action zero leaves output state unchanged on match.
// (RL17) Counting sequence depends only on mode, never on action.
// (RL18) Non-PWM: set, clear, toggle; PWM: inverted or non-inverted.
// (RL19) Normal mode counts up and wraps from MAX to zero.
// (RL20) Normal overflow flag set as count becomes zero; only set.
// (RL21) Taking the overflow interrupt clears the overflow flag.
// (RL22) Normal mode accepts count writes at any time.
// (RL23) Max and zero indications handle extreme compare values.
// (RL24) Mode 2 clears the count when it equals compare A.
// (RL25) Modes 3 and 7 are fast PWM, top MAX or compare A.
// (RL26) Modes 1 and 5 are phase correct PWM, top MAX or compare A.
// (RL27) Count write wins over clear or count in the same cycle.
// (RL28) Buffer loads at top in fast PWM, at bottom in phase PWM.
module tmoc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire timer_tick,
    input wire [2:0] irq_ack,
    output wire [2:0] irq_req,
    input wire [1:0] pin_direction_bit,
    input wire [1:0] port_out_value,
    output reg [1:0] pin_out,
    output reg [1:0] pin_oe_n
);
    // Register state.
    reg [1:0] action_a_q;
    reg [1:0] action_b_q;
    reg [2:0] mode_q;
    reg [2:0] flags_q;
    reg [2:0] ien_q;
    reg block_q;
    reg [15:0] cmp_q;
    reg [15:0] buf_q;

    // Decoded bus strobes.
    wire acc;
    wire wr;
    wire [7:0] word;
    wire hit_ctrl;
    wire hit_force;
    wire hit_count;
    wire hit_cmpa;
    wire hit_cmpb;
    wire hit_flags;
    wire hit_ien;
    wire hit_stat;
    wire mapped;
    reg [31:0] rdata_d;

    // Counter and mode class.
    wire [7:0] cnt;
    wire up;
    wire ovf_ev;
    wire wrap_ev;
    wire pwm;
    wire fast;
    wire phase;
    wire [7:0] top;
    wire reload;
    wire cnt_wr;
    wire match_en;
    wire rising;

    // Per channel.
    wire [1:0] match;
    wire [1:0] match_ev;
    wire [1:0] force_ev;
    wire [1:0] wr_cmp;
    wire [1:0] state;
    wire [3:0] action;
    wire [2:0] set_ev;
    wire [2:0] clr_ev;
    wire [15:0] buf_d;
    wire [15:0] cmp_d;
    wire [1:0] pin_d;

    // Zero wait state slave; access phase completes at once.
    assign pready = 1'b1;
    assign acc = psel & penable;
    assign wr = acc & pwrite & mapped;
    assign word = {paddr[7:2], 2'h0};

    // Address decode on the word-aligned byte address; the two low bits are ignored.
    assign hit_ctrl = (word == `TMOC_CTRL_OFF);
    assign hit_force = (word == `TMOC_FORCE_OFF);
    assign hit_count = (word == `TMOC_COUNT_OFF);
    assign hit_cmpa = (word == `TMOC_CMPA_OFF);
    assign hit_cmpb = (word == `TMOC_CMPB_OFF);
    assign hit_flags = (word == `TMOC_FLAGS_OFF);
    assign hit_ien = (word == `TMOC_IEN_OFF);
    assign hit_stat = (word == `TMOC_STAT_OFF);
    assign mapped = hit_ctrl | hit_force | hit_count | hit_cmpa | hit_cmpb |
                    hit_flags | hit_ien | hit_stat;

    // Mode classes.
    assign pwm = mode_q[0]; // [RL5]
    assign fast = mode_q[0] & mode_q[1];
    assign phase = mode_q[0] & ~mode_q[1];

    // Top is compare A in mode 2 and in modes 4 to 7, otherwise MAX. [RL24] [RL25] [RL26]
    assign top = (mode_q[2] || mode_q == `TMOC_MODE_CTC) ? cmp_q[7:0] : `TMOC_MAX;

    assign cnt_wr = wr & hit_count;
    assign action = {action_b_q, action_a_q};

    // Matches are suppressed in the tick after a count write. [RL8]
    assign match_en = timer_tick & ~block_q & ~cnt_wr;

    // Phase PWM slope seen by the compare unit; bottom counts as rising. [RL23]
    assign rising = (cnt == `TMOC_BOTTOM) | ((cnt != top) & up);

    // Buffer copies into active compare at top in fast, bottom in phase. [RL28]
    assign reload = timer_tick & ((fast & (cnt == top)) | (phase & (cnt == `TMOC_BOTTOM)));

    assign wr_cmp = {wr & hit_cmpb, wr & hit_cmpa};

    tmoc_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(timer_tick),
        .mode(mode_q),
        .top(top),
        .cnt_wr(cnt_wr),
        .cnt_wdata(pwdata[7:0]),
        .cnt_q(cnt),
        .up_q(up),
        .ovf_ev(ovf_ev),
        .wrap_ev(wrap_ev)
    );

    // One compare channel per generate step.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_ch
            // Comparator on the active compare value. [RL1]
            assign match[g] = (cnt == cmp_q[8*g+7:8*g]);
            assign match_ev[g] = match_en & match[g];

            // Force acts only in non-PWM modes. [RL7]
            assign force_ev[g] = wr & hit_force & pwdata[g] & ~pwm;

            // Software reaches the buffer in PWM modes, else the active value. [RL6]
            assign buf_d[8*g+7:8*g] = wr_cmp[g] ? pwdata[7:0] : buf_q[8*g+7:8*g];
            assign cmp_d[8*g+7:8*g] = (wr_cmp[g] && !pwm) ? pwdata[7:0] : // [RL5]
                                      (reload && pwm) ? buf_q[8*g+7:8*g] : // [RL28]
                                      cmp_q[8*g+7:8*g];

            tmoc_wave u_wave (
                .pclk(pclk),
                .presetn(presetn),
                .match_ev(match_ev[g]),
                .force_ev(force_ev[g]),
                .action(action[2*g+1:2*g]),
                .fast(fast),
                .phase(phase),
                .rising(rising),
                .wrap_ev(wrap_ev),
                .toggle_ok((g == 0) && mode_q[2]),
                .state_q(state[g])
            );

            // Nonzero action overrides the port value in every mode. [RL14] [RL15]
            assign pin_d[g] = (|action[2*g+1:2*g]) ? state[g] : port_out_value[g];
        end
    endgenerate

    // Compare, buffer and pin registers of both channels live in one process.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q <= {2{`TMOC_CMP_RST}};
            cmp_q <= {2{`TMOC_CMP_RST}};
            pin_out <= 2'h0;
            pin_oe_n <= 2'h3;
        end else begin
            buf_q <= buf_d;
            cmp_q <= cmp_d; // [RL5] [RL28]
            pin_out <= pin_d;
            pin_oe_n <= ~pin_direction_bit; // [RL14]
        end
    end

    // Flag events: overflow and the two channel matches; force never sets. [RL2] [RL20]
    assign set_ev = {match_ev[1], match_ev[0], ovf_ev};

    // Clears from write-one or interrupt taken. [RL4] [RL3] [RL21]
    assign clr_ev = ({3{wr & hit_flags}} & pwdata[2:0]) | irq_ack;

    // Interrupt request per enabled flag. [RL3]
    assign irq_req = flags_q & ien_q;

    // Flags: a set in the same cycle as a clear wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= (flags_q & ~clr_ev) | set_ev;
        end
    end

    // Block holds from a count write until the next timer tick passes. [RL8]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (cnt_wr) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // Control and enable registers; action writes act at once. [RL12]
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            action_a_q <= 2'h0;
            action_b_q <= 2'h0;
            mode_q <= 3'h0;
            ien_q <= 3'h0;
        end else begin
            if (wr && hit_ctrl) begin
                action_a_q <= pwdata[`TMOC_ACT_A_LSB+1:`TMOC_ACT_A_LSB];
                action_b_q <= pwdata[`TMOC_ACT_B_LSB+1:`TMOC_ACT_B_LSB];
                mode_q <= pwdata[`TMOC_MODE_LSB+2:`TMOC_MODE_LSB];
            end
            if (wr && hit_ien) begin
                ien_q <= pwdata[2:0];
            end
        end
    end

    // Read mux; compare reads follow the buffered view in PWM modes. [RL6]
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d[6:0] = {mode_q, action_b_q, action_a_q};
        end else if (hit_count) begin
            rdata_d[7:0] = cnt;
        end else if (hit_cmpa) begin
            rdata_d[7:0] = pwm ? buf_q[7:0] : cmp_q[7:0];
        end else if (hit_cmpb) begin
            rdata_d[7:0] = pwm ? buf_q[15:8] : cmp_q[15:8];
        end else if (hit_flags) begin
            rdata_d[2:0] = flags_q;
        end else if (hit_ien) begin
            rdata_d[2:0] = ien_q;
        end else if (hit_stat) begin
            rdata_d[2:0] = {up, state};
        end
    end

    // Read data and error are captured in the setup cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= ~mapped;
        end
    end
endmodule

`default_nettype wire

// >>> dv/tmoc_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tmoc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic timer_tick,
    input wire logic [2:0] irq_ack,
    input wire logic [2:0] irq_req,
    input wire logic [1:0] pin_direction_bit,
    input wire logic [1:0] port_out_value,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n
);
    logic wr_acc;
    logic [6:0] ctrl_q;

    // A completed write, and a shadow of the control word so that pin checks know the action.
    assign wr_acc = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 7'h00;
        end else if (wr_acc && paddr[7:2] == 6'h00) begin
            ctrl_q <= pwdata[6:0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dir_to_oe: assert property (1'b1 |=> pin_oe_n == ~$past(pin_direction_bit))
        else $error("pin enable does not follow the port direction");
    a_port_passthru: assert property (ctrl_q[1:0] == 2'h0 |=> pin_out[0] == $past(port_out_value[0]))
        else $error("port value not passed through with action zero");
    a_force_toggle: assert property (wr_acc && paddr[7:2] == 6'h01 && pwdata[0] && ctrl_q[1:0] == 2'h1
        && !ctrl_q[4] && !timer_tick |=> ##1 pin_out[0] != $past(pin_out[0]))
        else $error("forced toggle did not reach the pin");
    a_flag_a_cause: assert property ($rose(irq_req[1]) |-> $past(timer_tick) || $past(wr_acc))
        else $error("compare A request rose without a tick");
    a_ovf_cause: assert property ($rose(irq_req[0]) |-> $past(timer_tick) || $past(wr_acc))
        else $error("overflow request rose without a tick");
    a_ack_ovf: assert property (irq_req[0] && irq_ack[0] && !timer_tick |=> !irq_req[0])
        else $error("overflow flag not cleared by acknowledge");
    a_ack_cmp: assert property (irq_req[2] && irq_ack[2] && !timer_tick |=> !irq_req[2])
        else $error("compare B flag not cleared by acknowledge");
    a_sw_clear: assert property (wr_acc && paddr[7:2] == 6'h05 && pwdata[1] && !timer_tick
        |=> !irq_req[1])
        else $error("writing one did not clear compare A flag");
endmodule

bind tmoc_top tmoc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .timer_tick(timer_tick), .irq_ack(irq_ack), .irq_req(irq_req),
    .pin_direction_bit(pin_direction_bit), .port_out_value(port_out_value),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));

`default_nettype wire

// >>> dv/tmoc_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module tmoc_port_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] ddr_wr,
    input wire logic [1:0] port_wr,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    output logic [1:0] pin_direction_bit,
    output logic [1:0] port_out_value,
    output logic [1:0] pad
);
    logic [1:0] last_q;

    // Port registers hold what software last wrote; last_q feeds the floating pad.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_bit <= 2'h0;
            port_out_value <= 2'h0;
            last_q <= 2'h0;
        end else begin
            pin_direction_bit <= ddr_wr;
            port_out_value <= port_wr;
            last_q <= pad;
        end
    end

    // An undriven pad flips every cycle, so a stale level can never pass for a driven one.
    assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ~last_q);
endmodule

`default_nettype wire

// >>> dv/tb_timer8_output_compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmoc_map.vh"

module tb_timer8_output_compare_unit;
    logic pclk, presetn, psel, penable, pwrite, timer_tick, err_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic pready, pslverr;
    logic [2:0] irq_ack, irq_req;
    logic [1:0] ddr_wr, port_wr, pin_direction_bit, port_out_value, pin_out, pin_oe_n, pad;
    int n_mismatch, num_checks;
    logic [1:0] acts [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
    logic exps [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    tmoc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_tick(timer_tick), .irq_ack(irq_ack), .irq_req(irq_req),
        .pin_direction_bit(pin_direction_bit), .port_out_value(port_out_value),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    tmoc_port_model port_u (.pclk(pclk), .presetn(presetn), .ddr_wr(ddr_wr),
        .port_wr(port_wr), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_direction_bit(pin_direction_bit), .port_out_value(port_out_value), .pad(pad));

    // Free-running 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd_q);
    endtask

    task automatic tick(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        timer_tick <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic ack(input int b);
        irq_ack <= 3'h1 << b;
        @(posedge pclk);
        irq_ack <= 3'h0;
        @(posedge pclk);
    endtask

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end

    // Main sequence of scenarios.
    initial begin
        {presetn, psel, penable, pwrite, timer_tick, paddr, pwdata} = '0;
        {irq_ack, ddr_wr, port_wr} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", 32'h0, (i == 7) ? rd_q & 32'h3 : rd_q);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err_q});
        apb(1'b1, `TMOC_IEN_OFF, 32'h7);
        apb(1'b1, `TMOC_COUNT_OFF, 32'hFE);
        tick(2);
        chk("overflow request", 32'h1, {29'h0, irq_req});
        rdc(`TMOC_COUNT_OFF, 32'h0, "count wrap");
        ack(0);
        rdc(`TMOC_FLAGS_OFF, 32'h0, "overflow acked");
        apb(1'b1, `TMOC_CMPA_OFF, 32'h5);
        apb(1'b1, `TMOC_CMPB_OFF, 32'h5);
        apb(1'b1, `TMOC_COUNT_OFF, 32'h4);
        tick(2);
        chk("match requests", 32'h6, {29'h0, irq_req});
        apb(1'b1, `TMOC_FLAGS_OFF, 32'h2);
        rdc(`TMOC_FLAGS_OFF, 32'h4, "flag A cleared");
        ack(2);
        rdc(`TMOC_FLAGS_OFF, 32'h0, "flag B acked");
        // Count written equal to compare: the match is deliberately lost.
        apb(1'b1, `TMOC_CMPA_OFF, 32'h9);
        apb(1'b1, `TMOC_COUNT_OFF, 32'h9);
        tick(1);
        rdc(`TMOC_FLAGS_OFF, 32'h0, "blocked match");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `TMOC_CTRL_OFF, {30'h0, acts[i]});
            apb(1'b1, `TMOC_FORCE_OFF, 32'h1);
            apb(1'b0, `TMOC_STAT_OFF, 32'h0);
            chk("forced state", {31'h0, exps[i]}, rd_q & 32'h1);
        end
        rdc(`TMOC_FLAGS_OFF, 32'h0, "force sets no flag");
        rdc(`TMOC_COUNT_OFF, 32'hA, "force keeps count");
        // State is set first, then the pin is made an output.
        apb(1'b1, `TMOC_CTRL_OFF, 32'h3);
        apb(1'b1, `TMOC_FORCE_OFF, 32'h1);
        ddr_wr <= 2'h1;
        repeat (3) @(posedge pclk);
        chk("pin override", 32'h1, {31'h0, pad[0]});
        apb(1'b1, `TMOC_CTRL_OFF, 32'h0);
        @(posedge pclk);
        chk("pin port value", 32'h0, {31'h0, pad[0]});
        apb(1'b1, `TMOC_CTRL_OFF, 32'h20);
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("state kept", 32'h1, rd_q & 32'h1);
        port_wr <= 2'h1;
        apb(1'b1, `TMOC_CTRL_OFF, 32'h21);
        apb(1'b1, `TMOC_CMPA_OFF, 32'h3);
        apb(1'b1, `TMOC_COUNT_OFF, 32'h0);
        tick(4);
        rdc(`TMOC_COUNT_OFF, 32'h0, "clear on match");
        rdc(`TMOC_FLAGS_OFF, 32'h2, "clear match flag");
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("toggle on match", 32'h0, rd_q & 32'h1);
        chk("override in any mode", 32'h0, {31'h0, pad[0]});
        apb(1'b1, `TMOC_FLAGS_OFF, 32'h7);
        apb(1'b1, `TMOC_CTRL_OFF, 32'h33);
        apb(1'b1, `TMOC_FORCE_OFF, 32'h1);
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("force ignored in pwm", 32'h0, rd_q & 32'h1);
        apb(1'b1, `TMOC_CTRL_OFF, 32'h32);
        apb(1'b1, `TMOC_CMPA_OFF, 32'h11);
        rdc(`TMOC_CMPA_OFF, 32'h11, "buffer readback");
        apb(1'b1, `TMOC_COUNT_OFF, 32'h10);
        tick(2);
        rdc(`TMOC_FLAGS_OFF, 32'h0, "active value held");
        apb(1'b1, `TMOC_COUNT_OFF, 32'hFE);
        tick(2);
        rdc(`TMOC_FLAGS_OFF, 32'h1, "overflow at top");
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("set at bottom", 32'h1, rd_q & 32'h1);
        apb(1'b1, `TMOC_COUNT_OFF, 32'h10);
        tick(2);
        rdc(`TMOC_FLAGS_OFF, 32'h3, "match after reload");
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("cleared on match", 32'h0, rd_q & 32'h1);
        // Phase correct PWM: pass top, then match while counting down.
        apb(1'b1, `TMOC_FLAGS_OFF, 32'h7);
        apb(1'b1, `TMOC_CTRL_OFF, 32'h12);
        apb(1'b1, `TMOC_COUNT_OFF, 32'hFE);
        tick(3);
        apb(1'b1, `TMOC_COUNT_OFF, 32'h12);
        tick(2);
        apb(1'b0, `TMOC_STAT_OFF, 32'h0);
        chk("set on downcount", 32'h1, rd_q & 32'h5);
        rdc(`TMOC_FLAGS_OFF, 32'h2, "phase match flag");
        rdc(`TMOC_COUNT_OFF, 32'h10, "phase downcount");
        stop_test();
    end
endmodule

`default_nettype wire
